/* File: rtl/lscr_pkg.sv */
// Package with register map, field layout and timing constants of the LED switch register bank
package lscr_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_CHAN_B_HIGH = 8'h05;
   localparam logic [7:0] ADDR_CHAN_B_LOW = 8'h06;
   localparam logic [7:0] ADDR_CHAN_C_HIGH = 8'h07;
   localparam logic [7:0] ADDR_CHAN_C_LOW = 8'h08;
   localparam logic [7:0] ADDR_SWITCH_DIRECT = 8'h09;
   localparam logic [7:0] ADDR_MEASURE_MUX = 8'h0a;
   localparam logic [7:0] ADDR_DEAD_TIME = 8'h0b;
   localparam logic [7:0] ADDR_DIRECT_MODE = 8'h11;
   localparam logic [7:0] ADDR_SWITCH_STATUS = 8'h12;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_CHAN_HIGH = 8'h00;
   localparam logic [7:0] RST_CHAN_LOW = 8'h00;
   localparam logic [7:0] RST_SWITCH_DIRECT = 8'h00;
   localparam logic [7:0] RST_MEASURE_MUX = 8'h00;
   localparam logic [7:0] RST_DEAD_TIME = 8'h00;
   localparam logic RST_DIRECT_MODE = 1'b0;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CODE_HIGH_MSB = 1;
   localparam int SW_C_BIT = 7;
   localparam int SW_B_BIT = 6;
   localparam int SW_A_BIT = 5;
   localparam int UV_TRIM_MSB = 4;
   localparam int MUX_EN_BIT = 7;
   localparam int MUX_CAL_DIS_BIT = 6;
   localparam int MUX_GAIN_MSB = 5;
   localparam int MUX_GAIN_LSB = 4;
   localparam int MUX_SEL_MSB = 3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int SYNC_STAGES = 3;
   localparam int OFF_MIN_NS = 333;
   localparam int OFF_MAX_NS = 444;
   localparam int DEAD_FIRST_NS = 333;
   localparam int DEAD_STEP_NS = 111;
   // Off wait counted after the pin synchroniser and edge stage
   localparam logic [15:0] OFF_WAIT_NS = 16'(OFF_MIN_NS - SYNC_STAGES * CLK_PERIOD_NS);
   localparam int OFF_MIN_CYC = (OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_MAX_CYC = OFF_MAX_NS / CLK_PERIOD_NS;

   // Channel select decode
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_A = 2'h1;
   localparam logic [1:0] SEL_B = 2'h2;
   localparam logic [1:0] SEL_C = 2'h3;

   typedef enum logic [1:0]
   {
      SW_STEADY = 2'b00,
      SW_OFF_WAIT = 2'b01,
      SW_DEAD = 2'b10
   } lscr_sw_state_type;

endpackage

/* File: rtl/lscr_timer.sv */
// Delay timer with nanosecond targets, rounded up to whole clock cycles, for switch off wait and dead time
`timescale 1ns/100ps
module lscr_timer
   import lscr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic [15:0] target_ns_i,
   // Status
   output logic busy_o,
   output logic done_o
);

   logic [15:0] acc;
   logic [15:0] next_acc;
   logic [15:0] target;
   logic [15:0] next_target;
   logic busy;
   logic next_busy;
   logic done;
   logic next_done;
   logic [15:0] sum;

   // Accumulates elapsed ns so the least time rounds up to whole cycles
   always_comb
   begin
      sum = acc + 16'(CLK_PERIOD_NS);
      next_acc = acc;
      next_target = target;
      next_busy = busy;
      next_done = 1'b0;
      if (start_i)
      begin
         next_acc = 16'h0000;
         next_target = target_ns_i;
         next_busy = 1'b1;
      end
      else if (busy)
      begin
         next_acc = sum;
         if (sum >= target)
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         acc <= 16'h0000;
         target <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         target <= next_target;
         busy <= next_busy;
         done <= next_done;
      end
   end

   assign busy_o = busy;
   assign done_o = done;

endmodule

/* File: rtl/lscr_regs.sv */
// LED switch and current register bank with break-before-make channel switching
//
// Function
// [RULE1] Channel C code bits 9:8 at 07h
// [RULE2] Channel C code bits 7:0 at 08h
// [RULE3] Software keeps current codes at or below 307h
// [RULE4] Channel C code zero means zero current
// [RULE5] Channel B code uses same mapping
// [RULE6] Direct bits drive switches C, B, A
// [RULE7] Five-bit undervoltage trim, default zero
// [RULE8] Measure mux enable, cal, gain, select
// [RULE9] Eight-bit dead time register at 0Bh
// [RULE10] Dead time 0, 333 ns, plus 111 ns
// [RULE11] Switches off 333-444 ns after select change
// [RULE12] Upper high-register bits stored, no effect
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module lscr_regs
   import lscr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Channel select pin
   input wire logic [1:0] channel_select_input_i,
   // Current codes to the regulation DACs
   output logic [9:0] chan_b_current_code_o,
   output logic [9:0] chan_c_current_code_o,
   // Channel switches
   output logic chan_a_switch_o,
   output logic chan_b_switch_o,
   output logic chan_c_switch_o,
   // Analog controls
   output logic [4:0] undervoltage_trim_o,
   output logic measure_mux_enable_o,
   output logic measure_cal_disable_o,
   output logic [1:0] measure_gain_o,
   output logic [3:0] measure_input_select_o
);

   // ****************************************
   // Register state
   // ****************************************
   logic [7:0] chan_b_code_high;
   logic [7:0] chan_b_code_low;
   logic [7:0] chan_c_code_high;
   logic [7:0] chan_c_code_low;
   logic [7:0] switch_direct_bits;
   logic [7:0] measure_mux;
   logic [7:0] dead_time_code;
   logic direct_mode;
   logic [7:0] rdata;
   logic [7:0] next_chan_b_code_high;
   logic [7:0] next_chan_b_code_low;
   logic [7:0] next_chan_c_code_high;
   logic [7:0] next_chan_c_code_low;
   logic [7:0] next_switch_direct_bits;
   logic [7:0] next_measure_mux;
   logic [7:0] next_dead_time_code;
   logic next_direct_mode;
   logic [7:0] next_rdata;

   // ****************************************
   // Switch sequencing state
   // ****************************************
   logic [1:0] sel_meta;
   logic [1:0] sel_sync;
   logic [1:0] sel_last;
   logic [1:0] sel_target;
   logic [1:0] next_sel_target;
   lscr_sw_state_type sw_state;
   lscr_sw_state_type next_sw_state;
   logic [2:0] sw_on;
   logic [2:0] next_sw_on;
   logic timer_start;
   logic [15:0] timer_target;
   logic timer_busy;
   logic timer_done;
   logic [15:0] dead_ns;
   logic sel_changed;
   logic off_again;
   logic next_off_again;
   logic [2:0] sel_onehot;

   // ****************************************
   // Register writes and reads
   // ****************************************
   always_comb
   begin
      next_chan_b_code_high = chan_b_code_high;
      next_chan_b_code_low = chan_b_code_low;
      next_chan_c_code_high = chan_c_code_high;
      next_chan_c_code_low = chan_c_code_low;
      next_switch_direct_bits = switch_direct_bits;
      next_measure_mux = measure_mux;
      next_dead_time_code = dead_time_code;
      next_direct_mode = direct_mode;
      next_rdata = 8'h00;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            ADDR_CHAN_B_HIGH: next_chan_b_code_high = reg_wdata_i;
            ADDR_CHAN_B_LOW: next_chan_b_code_low = reg_wdata_i;
            // Spare upper bits are kept so software reads back what it wrote
            ADDR_CHAN_C_HIGH: next_chan_c_code_high = reg_wdata_i; // [RULE1] [RULE12]
            ADDR_CHAN_C_LOW: next_chan_c_code_low = reg_wdata_i; // [RULE2]
            ADDR_SWITCH_DIRECT: next_switch_direct_bits = reg_wdata_i; // [RULE6] [RULE7]
            ADDR_MEASURE_MUX: next_measure_mux = reg_wdata_i; // [RULE8]
            ADDR_DEAD_TIME: next_dead_time_code = reg_wdata_i; // [RULE9]
            ADDR_DIRECT_MODE: next_direct_mode = reg_wdata_i[0];
            default: next_direct_mode = direct_mode;
         endcase
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            ADDR_CHAN_B_HIGH: next_rdata = chan_b_code_high;
            ADDR_CHAN_B_LOW: next_rdata = chan_b_code_low;
            ADDR_CHAN_C_HIGH: next_rdata = chan_c_code_high;
            ADDR_CHAN_C_LOW: next_rdata = chan_c_code_low;
            ADDR_SWITCH_DIRECT: next_rdata = switch_direct_bits;
            ADDR_MEASURE_MUX: next_rdata = measure_mux;
            ADDR_DEAD_TIME: next_rdata = dead_time_code;
            ADDR_DIRECT_MODE: next_rdata = {7'h00, direct_mode};
            ADDR_SWITCH_STATUS: next_rdata = {1'b0, timer_busy, sw_state, sel_sync, sw_on[2], sw_on[1]};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         chan_b_code_high <= RST_CHAN_HIGH;
         chan_b_code_low <= RST_CHAN_LOW;
         chan_c_code_high <= RST_CHAN_HIGH;
         chan_c_code_low <= RST_CHAN_LOW;
         switch_direct_bits <= RST_SWITCH_DIRECT;
         measure_mux <= RST_MEASURE_MUX;
         dead_time_code <= RST_DEAD_TIME;
         direct_mode <= RST_DIRECT_MODE;
         rdata <= 8'h00;
      end
      else
      begin
         chan_b_code_high <= next_chan_b_code_high;
         chan_b_code_low <= next_chan_b_code_low;
         chan_c_code_high <= next_chan_c_code_high;
         chan_c_code_low <= next_chan_c_code_low;
         switch_direct_bits <= next_switch_direct_bits;
         measure_mux <= next_measure_mux;
         dead_time_code <= next_dead_time_code;
         direct_mode <= next_direct_mode;
         rdata <= next_rdata;
      end
   end

   // ****************************************
   // Channel select synchroniser
   // ****************************************
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sel_meta <= SEL_NONE;
         sel_sync <= SEL_NONE;
         sel_last <= SEL_NONE;
      end
      else
      begin
         sel_meta <= channel_select_input_i;
         sel_sync <= sel_meta;
         sel_last <= sel_sync;
      end
   end

   assign sel_changed = (sel_sync != sel_last);

   // ****************************************
   // Per-channel select decode
   // ****************************************
   // Select code ch+1 picks switch ch; code 0 leaves all off
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++)
      begin : g_chan
         assign sel_onehot[ch] = (sel_target == 2'(ch + 1));
      end
   endgenerate

   // ****************************************
   // Break-before-make sequencing
   // ****************************************
   // Code 0 gives no dead time beyond the one cycle the timer needs
   assign dead_ns = (dead_time_code == 8'h00) ? 16'h0000 :
      16'(DEAD_FIRST_NS) + 16'(DEAD_STEP_NS) * {8'h00, dead_time_code - 8'h01}; // [RULE10]

   always_comb
   begin
      next_sw_state = sw_state;
      next_sw_on = sw_on;
      next_sel_target = sel_target;
      next_off_again = off_again;
      timer_start = 1'b0;
      timer_target = OFF_WAIT_NS;
      if (next_direct_mode)
      begin
         // Direct mode bypasses sequencing; software owns the overlap
         next_sw_on = {next_switch_direct_bits[SW_C_BIT], next_switch_direct_bits[SW_B_BIT],
            next_switch_direct_bits[SW_A_BIT]}; // [RULE6]
         next_sw_state = SW_STEADY;
         next_sel_target = sel_sync;
         next_off_again = 1'b0;
      end
      else if (direct_mode)
      begin
         // Leaving direct mode: all off, a full dead time, then the pin rules
         next_sw_on = 3'b000;
         next_sel_target = sel_sync;
         next_off_again = 1'b0;
         timer_start = 1'b1;
         timer_target = dead_ns; // [RULE9]
         next_sw_state = SW_DEAD;
      end
      else
      begin
         case (sw_state)
            SW_STEADY:
            begin
               next_sw_state = SW_STEADY;
            end
            SW_OFF_WAIT:
            begin
               if (timer_done)
               begin
                  next_sw_on = 3'b000; // [RULE11]
                  timer_start = 1'b1;
                  if (off_again)
                  begin
                     // A later change gets its own full off wait, switches held off
                     timer_target = OFF_WAIT_NS;
                     next_off_again = 1'b0;
                  end
                  else
                  begin
                     timer_target = dead_ns; // [RULE9]
                     next_sw_state = SW_DEAD;
                  end
               end
            end
            SW_DEAD:
            begin
               if (timer_done)
               begin
                  next_sw_on = sel_onehot;
                  next_sw_state = SW_STEADY;
               end
            end
            default:
            begin
               next_sw_on = 3'b000;
               next_sw_state = SW_STEADY;
            end
         endcase
         if (sel_changed)
         begin
            next_sel_target = sel_sync;
            if (sw_state == SW_OFF_WAIT && !timer_done)
            begin
               // Keep the running wait so the first change still meets its window
               next_off_again = 1'b1; // [RULE11]
            end
            else
            begin
               // Switches already off in dead time stay off
               if (sw_state == SW_DEAD)
               begin
                  next_sw_on = 3'b000;
               end
               timer_start = 1'b1;
               timer_target = OFF_WAIT_NS;
               next_off_again = 1'b0;
               next_sw_state = SW_OFF_WAIT;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sw_state <= SW_STEADY;
         sw_on <= 3'b000;
         sel_target <= SEL_NONE;
         off_again <= 1'b0;
      end
      else
      begin
         sw_state <= next_sw_state;
         sw_on <= next_sw_on;
         sel_target <= next_sel_target;
         off_again <= next_off_again;
      end
   end

   lscr_timer u_timer
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(timer_start),
      .target_ns_i(timer_target),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata_o = rdata;
   // Codes pass unclamped; the DAC maps 0 to zero current, rising monotonic
   assign chan_b_current_code_o = {chan_b_code_high[CODE_HIGH_MSB:0], chan_b_code_low}; // [RULE5]
   assign chan_c_current_code_o = {chan_c_code_high[CODE_HIGH_MSB:0], chan_c_code_low}; // [RULE1] [RULE2] [RULE4]
   assign chan_a_switch_o = sw_on[0];
   assign chan_b_switch_o = sw_on[1];
   assign chan_c_switch_o = sw_on[2];
   assign undervoltage_trim_o = switch_direct_bits[UV_TRIM_MSB:0]; // [RULE7]
   assign measure_mux_enable_o = measure_mux[MUX_EN_BIT]; // [RULE8]
   assign measure_cal_disable_o = measure_mux[MUX_CAL_DIS_BIT];
   assign measure_gain_o = measure_mux[MUX_GAIN_MSB:MUX_GAIN_LSB];
   assign measure_input_select_o = measure_mux[MUX_SEL_MSB:0];

endmodule

/* File: tb/lscr_regs_sva.sv */
// Port checker for the LED switch register bank
`timescale 1ns/100ps
module lscr_regs_sva
   import lscr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Pin and outputs
   input wire logic [1:0] channel_select_input_i,
   input wire logic [9:0] chan_b_current_code_o,
   input wire logic [9:0] chan_c_current_code_o,
   input wire logic chan_a_switch_o,
   input wire logic chan_b_switch_o,
   input wire logic chan_c_switch_o,
   input wire logic [4:0] undervoltage_trim_o,
   input wire logic measure_mux_enable_o,
   input wire logic measure_cal_disable_o,
   input wire logic [1:0] measure_gain_o,
   input wire logic [3:0] measure_input_select_o
);
   // ***************************************
   // Direct mode shadow and assertions
   // ***************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic dm;
   logic next_dm;
   logic [2:0] sw;
   assign sw = {chan_c_switch_o, chan_b_switch_o, chan_a_switch_o};
   always_comb
   begin
      next_dm = dm;
      if (reg_wr_i && reg_addr_i == ADDR_DIRECT_MODE)
      begin
         next_dm = reg_wdata_i[0];
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      dm <= rst_i ? 1'b0 : next_dm;
   end
   a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read cycle");
   a_code_c_high: assert property (reg_wr_i && reg_addr_i == ADDR_CHAN_C_HIGH |=>
      chan_c_current_code_o[9:8] == $past(reg_wdata_i[1:0])) else $error("chan c code high bits wrong");
   a_code_c_low: assert property (reg_wr_i && reg_addr_i == ADDR_CHAN_C_LOW |=>
      chan_c_current_code_o[7:0] == $past(reg_wdata_i)) else $error("chan c code low byte wrong");
   a_code_b_low: assert property (reg_wr_i && reg_addr_i == ADDR_CHAN_B_LOW |=>
      chan_b_current_code_o[7:0] == $past(reg_wdata_i)) else $error("chan b code low byte wrong");
   a_trim_write: assert property (reg_wr_i && reg_addr_i == ADDR_SWITCH_DIRECT |=>
      undervoltage_trim_o == $past(reg_wdata_i[4:0])) else $error("trim output wrong");
   a_mux_write: assert property (reg_wr_i && reg_addr_i == ADDR_MEASURE_MUX |=> {measure_mux_enable_o,
      measure_cal_disable_o, measure_gain_o, measure_input_select_o} == $past(reg_wdata_i))
      else $error("measure controls wrong");
   a_direct_follow: assert property (dm && reg_wr_i && reg_addr_i == ADDR_SWITCH_DIRECT |=>
      sw == $past(reg_wdata_i[7:5])) else $error("direct switches wrong");
   a_switch_exclusive: assert property (!dm |-> $onehot0(sw))
      else $error("two switches on at once");
   a_select_off: assert property (!dm && $changed(channel_select_input_i) |-> ##[16:21] sw == 3'b000)
      else $error("switches not off after select change");
   c_read: cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
   c_switch_on: cover property (!dm && $rose(chan_c_switch_o));
   c_direct: cover property (dm && sw == 3'b111);
endmodule

bind lscr_regs lscr_regs_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .channel_select_input_i(channel_select_input_i), .chan_b_current_code_o(chan_b_current_code_o),
   .chan_c_current_code_o(chan_c_current_code_o), .chan_a_switch_o(chan_a_switch_o),
   .chan_b_switch_o(chan_b_switch_o), .chan_c_switch_o(chan_c_switch_o),
   .undervoltage_trim_o(undervoltage_trim_o), .measure_mux_enable_o(measure_mux_enable_o),
   .measure_cal_disable_o(measure_cal_disable_o), .measure_gain_o(measure_gain_o),
   .measure_input_select_o(measure_input_select_o));

/* File: tb/lscr_host.sv */
// Display processor model: register port master and channel select pin
`timescale 1ns/100ps
module lscr_host
(
   // Clock
   input wire logic core_clk_i,
   // Register port
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i,
   // Channel select pin
   output logic [1:0] channel_select_input_o
);
   // ***************************************
   // Bus tasks
   // ***************************************
   initial
   begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      channel_select_input_o = 2'h0;
   end
   // Callers keep codes at or below 307h, spare high bits zero
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      // Released bus shows no stale value
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rdata_i;
   endtask
   task automatic sel(input logic [1:0] v);
      @(posedge core_clk_i);
      channel_select_input_o <= v;
   endtask
endmodule

/* File: tb/test_lscr_regs.sv */
// Self-checking bench for the LED switch register bank
`timescale 1ns/100ps
module test_lscr_regs
   import lscr_pkg::*;
;
   typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} lscr_row_type;
   logic clk;
   logic rst;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd;
   logic [1:0] sel;
   logic [9:0] code_b, code_c;
   logic sw_a, sw_b, sw_c, mux_en, cal_dis;
   logic [4:0] trim;
   logic [1:0] gain;
   logic [3:0] msel;
   logic [2:0] sw;
   int fails, n_checks, n;
   lscr_row_type rows [9] = '{'{8'h07, 8'h03, 8'h03}, '{8'h08, 8'h07, 8'h07}, '{8'h05, 8'h02, 8'h02},
      '{8'h06, 8'hff, 8'hff}, '{8'h09, 8'h1f, 8'h1f}, '{8'h0a, 8'ha5, 8'ha5}, '{8'h0b, 8'h01, 8'h01},
      '{8'h20, 8'h5a, 8'h00}, '{8'h12, 8'h5a, 8'h00}};
   assign sw = {sw_c, sw_b, sw_a};

   lscr_host host (.core_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_rdata_i(rdata), .channel_select_input_o(sel));
   lscr_regs DUT (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .channel_select_input_i(sel), .chan_b_current_code_o(code_b),
      .chan_c_current_code_o(code_c), .chan_a_switch_o(sw_a), .chan_b_switch_o(sw_b), .chan_c_switch_o(sw_c),
      .undervoltage_trim_o(trim), .measure_mux_enable_o(mux_en), .measure_cal_disable_o(cal_dis),
      .measure_gain_o(gain), .measure_input_select_o(msel));

   // ***************************************
   // Helpers
   // ***************************************
   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Cycles from the select change edge until switch b turns on
   task automatic meas(input int b, output int k);
      k = 0;
      while (sw[b] !== 1'b1 && k < 3000)
      begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      #(20 * 6000);
      fails++;
      end_of_test();
   end

   // ***************************************
   // Tests
   // ***************************************
   initial
   begin
      fails = 0;
      n_checks = 0;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         host.rd(rows[i].addr, d);
         chk("reset value", {2'b00, d}, 10'h000);
      end
      chk("reset code c", code_c, 10'h000);
      $display("reset test done");
      foreach (rows[i])
      begin
         host.wr(rows[i].addr, rows[i].data);
         host.rd(rows[i].addr, d);
         chk("readback", {2'b00, d}, {2'b00, rows[i].exp});
      end
      chk("code c", code_c, 10'h307);
      chk("code b", code_b, 10'h2ff);
      chk("trim", {5'h00, trim}, 10'h01f);
      chk("measure", {2'b00, mux_en, cal_dis, gain, msel}, 10'h0a5);
      $display("table test done");
      host.sel(SEL_A);
      meas(0, n);
      chk("on delay code 01", 10'(n >= 34 && n <= 41), 10'h001);
      host.wr(ADDR_DEAD_TIME, 8'hff);
      host.sel(SEL_C);
      meas(2, n);
      chk("on delay code ff", 10'(n >= 1444 && n <= 1452), 10'h001);
      chk("only c on", {7'h00, sw}, 10'h004);
      $display("dead time test done");
      host.wr(ADDR_DEAD_TIME, 8'h00);
      host.sel(SEL_B);
      repeat (8) @(posedge clk);
      host.sel(SEL_A);
      meas(0, n);
      // Second change inside the first off wait: off held, then a fresh wait
      chk("restart delay", 10'(n >= 18 && n <= 30), 10'h001);
      chk("only a on", {7'h00, sw}, 10'h001);
      $display("restart test done");
      host.wr(ADDR_SWITCH_DIRECT, 8'h00);
      host.wr(ADDR_DIRECT_MODE, 8'h01);
      host.wr(ADDR_SWITCH_DIRECT, 8'he0);
      #1;
      chk("direct all on", {7'h00, sw}, 10'h007);
      host.wr(ADDR_SWITCH_DIRECT, 8'h40);
      #1;
      chk("direct b only", {7'h00, sw}, 10'h002);
      host.wr(ADDR_SWITCH_DIRECT, 8'h00);
      host.wr(ADDR_DIRECT_MODE, 8'h00);
      repeat (4) @(posedge clk);
      #1;
      chk("pin after direct", {7'h00, sw}, 10'h001);
      $display("direct test done");
      end_of_test();
   end
endmodule
